//--- inc/attach_phy_pkg.sv
// Purpose: Constants for the Type-C attach and PHY enable block
// Assumes: Used with package-qualified names only
// Notes:   Port counts are the defaults of the top module
package attach_phy_pkg;

  localparam int          NUM_ATTACH_PORTS = 3;
  localparam int          NUM_MUX_PORTS    = 2;
  localparam int          SYNC_STAGES      = 2;
  localparam logic        RESET_PHY_EN     = 1'b0;
  localparam logic        RESET_SYNC_BIT   = 1'b0;
  localparam logic        MODE_PER_PORT    = 1'b0;
  localparam logic        MODE_ALTERNATIVE = 1'b1;
  localparam logic        ORIENT_B_RAW     = 1'b1;

endpackage

//--- rtl/typec_attach_phy_enable.sv
// Purpose: SuperSpeed PHY power and orientation select from Type-C attach pins
// Assumes: Pins are asynchronous levels; one core clock
// Notes:   Outputs change three clock edges after a pin settles
// Notes:   Straps are sampled continuously, not latched at reset
`timescale 1ns/10ps
module typec_attach_phy_enable #(
  parameter int NUM_ATTACH_PORTS = attach_phy_pkg::NUM_ATTACH_PORTS,
  parameter int NUM_MUX_PORTS    = attach_phy_pkg::NUM_MUX_PORTS
) (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  // Straps
  input  wire logic                        attach_polarity_sel,
  input  wire logic                        control_mode_sel,
  // Per-port mode pins
  input  wire logic [NUM_ATTACH_PORTS-1:0] attach_detect_in,
  input  wire logic [NUM_MUX_PORTS-1:0]    orientation_sel_in,
  // Alternative mode pins
  input  wire logic [NUM_MUX_PORTS-1:0]    alt_attach_orient_a_in,
  input  wire logic [NUM_MUX_PORTS-1:0]    alt_attach_orient_b_in,
  // PHY controls
  output logic      [NUM_ATTACH_PORTS-1:0] ss_phy_pwr_en,
  output logic      [NUM_MUX_PORTS-1:0]    phy_a_en,
  output logic      [NUM_MUX_PORTS-1:0]    phy_b_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check

  localparam int SYNC_W = NUM_ATTACH_PORTS + 3 * NUM_MUX_PORTS + 2;

  if (NUM_MUX_PORTS < 1 || NUM_ATTACH_PORTS < NUM_MUX_PORTS)
  begin : g_bad_params
    $error("Mux ports must be between one and the attach port count");
  end

  if (attach_phy_pkg::SYNC_STAGES != 2)
  begin : g_bad_sync
    $error("Synchroniser is built with two stages");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active level of a pin under the polarity strap

  function automatic logic pin_active(input logic raw, input logic pol);
  begin
    pin_active = raw ^ pol;
  end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Source of an enable under the control-mode strap

  function automatic logic mode_pick(input logic alt, input logic alt_val, input logic pp_val);
  begin
    mode_pick = alt ? alt_val : pp_val;
  end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser

  logic [SYNC_W-1:0] pins_sync;
  logic [SYNC_W-1:0] pins_raw;

  assign pins_raw = {attach_polarity_sel, control_mode_sel, attach_detect_in,
                     orientation_sel_in, alt_attach_orient_a_in, alt_attach_orient_b_in};

  for (genvar i = 0; i < SYNC_W; i++)
  begin : g_sync
    logic stage1_q;
    logic stage2_q;

    // First stage, read only by the second
    always_ff @(posedge clk_sys)
    begin
      if (reset)
      begin
        stage1_q <= attach_phy_pkg::RESET_SYNC_BIT;
      end
      else
      begin
        stage1_q <= pins_raw[i];
      end
    end

    // Second stage feeds the decode
    always_ff @(posedge clk_sys)
    begin
      if (reset)
      begin
        stage2_q <= attach_phy_pkg::RESET_SYNC_BIT;
      end
      else
      begin
        stage2_q <= stage1_q;
      end
    end

    assign pins_sync[i] = stage2_q;
  end

  logic                        pol_s;
  logic                        mode_s;
  logic [NUM_ATTACH_PORTS-1:0] attach_s;
  logic [NUM_MUX_PORTS-1:0]    orient_s;
  logic [NUM_MUX_PORTS-1:0]    alt_a_s;
  logic [NUM_MUX_PORTS-1:0]    alt_b_s;

  assign {pol_s, mode_s, attach_s, orient_s, alt_a_s, alt_b_s} = pins_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Enable decode

  logic                        alt_mode;
  logic [NUM_ATTACH_PORTS-1:0] attach_act;
  logic [NUM_MUX_PORTS-1:0]    orient_act;
  logic [NUM_MUX_PORTS-1:0]    alt_a_act;
  logic [NUM_MUX_PORTS-1:0]    alt_b_act;
  logic [NUM_ATTACH_PORTS-1:0] pwr_d;
  logic [NUM_MUX_PORTS-1:0]    a_d;
  logic [NUM_MUX_PORTS-1:0]    b_d;

  assign alt_mode = (mode_s == attach_phy_pkg::MODE_ALTERNATIVE);

  ////////////////////////////////////////////////////////////////////////////
  // Polarity strap on every attach pin

  for (genvar p = 0; p < NUM_ATTACH_PORTS; p++)
  begin : g_attach_act
    assign attach_act[p] = pin_active(attach_s[p], pol_s);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Polarity strap on orientation and alternative pins

  for (genvar m = 0; m < NUM_MUX_PORTS; m++)
  begin : g_mux_act
    assign orient_act[m] = pin_active(orient_s[m], pol_s);
    assign alt_a_act[m]  = pin_active(alt_a_s[m], pol_s);
    assign alt_b_act[m]  = pin_active(alt_b_s[m], pol_s);
  end

  for (genvar p = 0; p < NUM_ATTACH_PORTS; p++)
  begin : g_port
    if (p < NUM_MUX_PORTS)
    begin : g_mux
      logic orient_b;
      logic pp_a;
      logic pp_b;
      assign orient_b = (orient_act[p] == attach_phy_pkg::ORIENT_B_RAW);
      assign pp_a     = attach_act[p] & ~orient_b;
      assign pp_b     = attach_act[p] & orient_b;
      assign a_d[p]   = mode_pick(alt_mode, alt_a_act[p], pp_a);
      assign b_d[p]   = mode_pick(alt_mode, alt_b_act[p], pp_b);
      assign pwr_d[p] = a_d[p] | b_d[p];
    end
    else
    begin : g_plain
      assign pwr_d[p] = mode_pick(alt_mode, 1'b0, attach_act[p]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  // Port power
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ss_phy_pwr_en <= {NUM_ATTACH_PORTS{attach_phy_pkg::RESET_PHY_EN}};
    end
    else
    begin
      ss_phy_pwr_en <= pwr_d;
    end
  end

  // PHY A select
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      phy_a_en <= {NUM_MUX_PORTS{attach_phy_pkg::RESET_PHY_EN}};
    end
    else
    begin
      phy_a_en <= a_d;
    end
  end

  // PHY B select
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      phy_b_en <= {NUM_MUX_PORTS{attach_phy_pkg::RESET_PHY_EN}};
    end
    else
    begin
      phy_b_en <= b_d;
    end
  end

endmodule

//--- bench/attach_phy_properties.sv
// Purpose: Checks on the PHY enable decode
// Assumes: Outputs follow pins after three edges
// Notes:   Bound from the testbench
`timescale 1ns/10ps
module attach_phy_properties #(
  parameter int NUM_ATTACH_PORTS = 3,
  parameter int NUM_MUX_PORTS    = 2
) (
  input wire logic clk_sys, reset, attach_polarity_sel, control_mode_sel,
  input wire logic [NUM_ATTACH_PORTS-1:0] attach_detect_in, ss_phy_pwr_en,
  input wire logic [NUM_MUX_PORTS-1:0] orientation_sel_in, phy_a_en, phy_b_en,
  input wire logic [NUM_MUX_PORTS-1:0] alt_attach_orient_a_in, alt_attach_orient_b_in
);
  localparam int M = NUM_MUX_PORTS;
  logic [2:0]   rh_q = 3'h7;
  logic [2:0]   pol_q;
  logic [M-1:0] pm;
  assign pm = {M{pol_q[2]}};
  always @(posedge clk_sys) rh_q <= {rh_q[1:0], reset};
  always_ff @(posedge clk_sys) pol_q <= {pol_q[1:0], attach_polarity_sel};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset || |rh_q);
  sequence s_alt; $past(control_mode_sel, 3); endsequence
  sequence s_per_port; !$past(control_mode_sel, 3); endsequence
  a_port_two_pwr: assert property (
    ss_phy_pwr_en[M] == (!$past(control_mode_sel, 3) && ($past(attach_detect_in[M], 3) ^ pol_q[2])))
    else $error("port two power wrong");
  a_pwr_is_or: assert property (ss_phy_pwr_en[M-1:0] == (phy_a_en | phy_b_en))
    else $error("power not A or B");
  a_per_port_a: assert property (s_per_port |-> phy_a_en ==
    (($past(attach_detect_in[M-1:0], 3) ^ pm) & ~($past(orientation_sel_in, 3) ^ pm)))
    else $error("per-port A wrong");
  a_per_port_b: assert property (s_per_port |-> phy_b_en ==
    (($past(attach_detect_in[M-1:0], 3) ^ pm) & ($past(orientation_sel_in, 3) ^ pm)))
    else $error("per-port B wrong");
  a_alt_orient_a: assert property (
    s_alt |-> phy_a_en == ($past(alt_attach_orient_a_in, 3) ^ pm)) else $error("alt A wrong");
  a_alt_orient_b: assert property (
    s_alt |-> phy_b_en == ($past(alt_attach_orient_b_in, 3) ^ pm)) else $error("alt B wrong");
  a_alt_port_off: assert property (s_alt |-> ss_phy_pwr_en[NUM_ATTACH_PORTS-1:M] == '0)
    else $error("unmuxed port on in alt mode");
  a_reset_clear: assert property (disable iff (1'b0) reset |=>
    ss_phy_pwr_en == '0 && phy_a_en == '0 && phy_b_en == '0) else $error("reset left PHY on");
endmodule

//--- bench/cc_detect_model.sv
// Purpose: Connector side attach and orientation source
// Assumes: Pin levels move on falling edges
// Notes:   Order is attach, orientation, alt A, alt B
`timescale 1ns/10ps
module cc_detect_model (
  input  wire logic       clk_sys,
  input  wire logic [8:0] pin_cmd,
  output logic      [8:0] pins = 9'h000
);
  // Every pin, attach lines included, follows pin_cmd
  always @(negedge clk_sys) pins <= pin_cmd;
endmodule

//--- bench/testbench.sv
// Purpose: Self-checking bench for the PHY enable block
// Assumes: Default port counts
// Notes:   Rows hold straps, pins and expected enables
`timescale 1ns/10ps
module testbench;
  logic        clk_sys = 1'b0;
  logic        reset   = 1'b1;
  logic [1:0]  strap   = 2'h0;
  logic [8:0]  pin_cmd = 9'h000;
  logic [8:0]  pins;
  logic [2:0]  pwr;
  logic [1:0]  pa, pb;
  int          error_cnt = 0;
  int          comparisons = 0;
  logic [17:0] rows [9] = '{18'h0_2014, 18'h0_F873, 18'h0_CFE8, 18'h2_187C, 18'h2_D011,
                            18'h1_FB36, 18'h1_07BF, 18'h3_E339, 18'h0_E07C};
  typec_attach_phy_enable typec_attach_phy_enable_i (.clk_sys, .reset,
    .attach_polarity_sel(strap[1]), .control_mode_sel(strap[0]),
    .attach_detect_in(pins[8:6]), .orientation_sel_in(pins[5:4]),
    .alt_attach_orient_a_in(pins[3:2]), .alt_attach_orient_b_in(pins[1:0]),
    .ss_phy_pwr_en(pwr), .phy_a_en(pa), .phy_b_en(pb));
  cc_detect_model cc_detect_model_i (.clk_sys, .pin_cmd, .pins);
  task automatic check(string name, logic [6:0] seen, logic [6:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (2000) @(posedge clk_sys);
    error_cnt++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(negedge clk_sys);
    reset <= 1'b0;
    foreach (rows[i])
    begin
      {strap, pin_cmd} <= rows[i][17:7];
      repeat (4) @(negedge clk_sys);
      check("enables", {pwr, pa, pb}, rows[i][6:0]);
    end
    pin_cmd <= 9'h000;
    repeat (3) @(negedge clk_sys);
    check("lag", {pwr, pa, pb}, 7'h7C);
    @(negedge clk_sys);
    check("detach", {pwr, pa, pb}, 7'h00);
    pin_cmd <= 9'h1F0;
    repeat (4) @(negedge clk_sys);
    reset <= 1'b1;
    @(negedge clk_sys);
    check("reset", {pwr, pa, pb}, 7'h00);
    reset <= 1'b0;
    repeat (2)
    begin
      @(negedge clk_sys);
      check("release", {pwr, pa, pb}, 7'h00);
    end
    @(negedge clk_sys);
    check("resume", {pwr, pa, pb}, 7'h73);
    complete_run();
  end
endmodule
bind typec_attach_phy_enable attach_phy_properties #(.NUM_ATTACH_PORTS(NUM_ATTACH_PORTS),
  .NUM_MUX_PORTS(NUM_MUX_PORTS)) attach_phy_properties_i (.clk_sys, .reset,
  .attach_polarity_sel, .control_mode_sel, .attach_detect_in, .orientation_sel_in,
  .alt_attach_orient_a_in, .alt_attach_orient_b_in, .ss_phy_pwr_en, .phy_a_en, .phy_b_en);
